/* File: inc/ssr_cfg.svh */
// constants for the slot repeat block: register offsets, field layout, timing
// assumes a 25 MHz clock and an 8-bit register port with byte offsets
`ifndef SSR_CFG_SVH
`define SSR_CFG_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define SSR_ADDR_REPEAT_FIRST 8'h17
`define SSR_ADDR_REPEAT_LAST 8'h18
`define SSR_REPEAT_RESET 8'h00

// ----------------------------------------
// field layout and sequence shape
// ----------------------------------------
`define SSR_FIELD_W 2
`define SSR_SLOTS 8
`define SSR_SLOTS_PER_REG 4

// ----------------------------------------
// timing
// ----------------------------------------
`define SSR_CLK_HZ 25000000
`define SSR_DELAY_UNIT_MS 10
`define SSR_DELAY_UNIT_CYCLES ((`SSR_CLK_HZ / 1000) * `SSR_DELAY_UNIT_MS)

`endif

/* File: inc/ssr_pkg.sv */
// types shared by the slot repeat block
// assumes ssr_cfg.svh is on the include path
package ssr_pkg;
   // one slot entry: delay flag plus 7-bit value
   typedef struct packed {
      logic delay_flag;
      logic [6:0] effect_value;
   } ssr_entry_t;

   // register port request
   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } ssr_req_t;

   typedef enum logic [1:0] {
      SSR_IDLE = 2'b00,
      SSR_LOAD = 2'b01,
      SSR_PLAY = 2'b10,
      SSR_WAIT = 2'b11
   } ssr_state_t;
endpackage

/* File: src/ssr_delay_timer.sv */
// countdown timer for wait entries: value x 10 ms
// assumes start is a one-cycle pulse while the timer is idle
`timescale 1ns/1ps
`default_nettype none
`include "ssr_cfg.svh"

module ssr_delay_timer #(
   parameter int UNIT_CYCLES = `SSR_DELAY_UNIT_CYCLES
) (
   input wire logic clock,
   input wire logic resetn,
   input wire logic start,
   input wire logic [6:0] units,
   output logic done
);
   logic [6:0] units_r;
   logic [31:0] tick_r;
   logic busy_r;
   wire tick_end = (tick_r == 32'(UNIT_CYCLES - 1));

   // ----------------------------------------
   // countdown
   // ----------------------------------------
   // a zero-length wait finishes one cycle after start so the sequencer never stalls
   always_ff @(posedge clock) begin
      if (!resetn) begin
         units_r <= 7'h00;
         tick_r <= 32'h0;
         busy_r <= 1'b0;
         done <= 1'b0;
      end else begin
         done <= 1'b0;
         if (start) begin
            units_r <= units;
            tick_r <= 32'h0;
            busy_r <= (units != 7'h00);
            done <= (units == 7'h00);
         end else if (busy_r) begin
            tick_r <= tick_end ? 32'h0 : tick_r + 32'h1;
            if (tick_end) begin
               units_r <= units_r - 7'h01;
               if (units_r == 7'h01) begin
                  busy_r <= 1'b0;
                  done <= 1'b1;
               end
            end
         end
      end
   end
endmodule
`default_nettype wire

/* File: src/ssr_sequencer_repeat.sv */
// slot repeat registers and the slot walk of the playback sequencer
// assumes an 8-bit register port decoded upstream from the serial control port,
// slot entries supplied from their own registers, and a waveform engine with
// a start pulse and a done pulse
`timescale 1ns/1ps
`default_nettype none
`include "ssr_cfg.svh"

module ssr_sequencer_repeat
   import ssr_pkg::*;
#(
   parameter int SLOTS = `SSR_SLOTS,
   parameter int UNIT_CYCLES = `SSR_DELAY_UNIT_CYCLES
) (
   input wire logic clock,
   input wire logic resetn,
   input wire ssr_req_t reg_req,
   output logic [7:0] reg_rdata,
   output logic reg_hit,
   input wire ssr_entry_t [SLOTS-1:0] slot_entries,
   input wire logic go,
   output logic effect_start,
   output logic [6:0] effect_id,
   input wire logic effect_done,
   output logic busy,
   output logic [2:0] active_slot,
   output logic [1:0] repeat_index
);
   // ----------------------------------------
   // repeat registers
   // ----------------------------------------
   logic [7:0] repeat_first_r;
   logic [7:0] repeat_last_r;
   logic [2*SLOTS-1:0] repeat_fields;

   // slot k uses bits 2k+1:2k of the joined pair, so 5-4 of the first is slot two
   assign repeat_fields = {repeat_last_r, repeat_first_r};

   function automatic logic [1:0] repeat_of(input logic [2*SLOTS-1:0] f, input logic [2:0] s);
      repeat_of = f[2*s +: 2];
   endfunction

   wire wr_first = reg_req.wr && (reg_req.addr == `SSR_ADDR_REPEAT_FIRST);
   wire wr_last = reg_req.wr && (reg_req.addr == `SSR_ADDR_REPEAT_LAST);
   wire rd_first = reg_req.rd && (reg_req.addr == `SSR_ADDR_REPEAT_FIRST);
   wire rd_last = reg_req.rd && (reg_req.addr == `SSR_ADDR_REPEAT_LAST);
   wire [7:0] rd_mux = rd_first ? repeat_first_r : (rd_last ? repeat_last_r : 8'h00);

   // host writes store whole bytes; reads answer the next cycle
   always_ff @(posedge clock) begin
      if (!resetn) begin
         repeat_first_r <= `SSR_REPEAT_RESET;
         repeat_last_r <= `SSR_REPEAT_RESET;
         reg_rdata <= 8'h00;
         reg_hit <= 1'b0;
      end else begin
         if (wr_first) repeat_first_r <= reg_req.wdata;
         if (wr_last) repeat_last_r <= reg_req.wdata;
         reg_rdata <= rd_mux;
         reg_hit <= rd_first || rd_last;
      end
   end

   // ----------------------------------------
   // slot walk
   // ----------------------------------------
   ssr_state_t state_r, state_nxt;
   logic [2:0] slot_r, slot_nxt;
   logic [1:0] pass_r, pass_nxt;
   logic start_nxt;
   logic timer_start;
   logic timer_done;
   ssr_entry_t cur;
   logic last_pass;
   logic last_slot;
   logic empty_slot;

   assign cur = slot_entries[slot_r];
   assign last_pass = (pass_r == repeat_of(repeat_fields, slot_r));
   assign last_slot = (slot_r == 3'(SLOTS - 1));
   // identifier zero ends the sequence; a wait entry is never an end marker
   assign empty_slot = !cur.delay_flag && (cur.effect_value == 7'h00);

   // one entry pass ends on the engine or the timer; only the final pass advances
   always_comb begin
      state_nxt = state_r;
      slot_nxt = slot_r;
      pass_nxt = pass_r;
      start_nxt = 1'b0;
      timer_start = 1'b0;
      case (state_r)
         SSR_IDLE: begin
            if (go) begin
               slot_nxt = 3'h0;
               pass_nxt = 2'h0;
               state_nxt = SSR_LOAD;
            end
         end
         SSR_LOAD: begin
            if (empty_slot) begin
               state_nxt = SSR_IDLE;
            end else if (cur.delay_flag) begin
               timer_start = 1'b1;
               state_nxt = SSR_WAIT;
            end else begin
               start_nxt = 1'b1;
               state_nxt = SSR_PLAY;
            end
         end
         SSR_PLAY, SSR_WAIT: begin
            if ((state_r == SSR_PLAY) ? effect_done : timer_done) begin
               state_nxt = SSR_LOAD;
               if (!last_pass) begin
                  pass_nxt = pass_r + 2'h1;
               end else if (last_slot) begin
                  state_nxt = SSR_IDLE;
               end else begin
                  pass_nxt = 2'h0;
                  slot_nxt = slot_r + 3'h1;
               end
            end
         end
         default: state_nxt = SSR_IDLE;
      endcase
   end

   always_ff @(posedge clock) begin
      if (!resetn) begin
         state_r <= SSR_IDLE;
         slot_r <= 3'h0;
         pass_r <= 2'h0;
         effect_start <= 1'b0;
         effect_id <= 7'h00;
         busy <= 1'b0;
         active_slot <= 3'h0;
         repeat_index <= 2'h0;
      end else begin
         state_r <= state_nxt;
         slot_r <= slot_nxt;
         pass_r <= pass_nxt;
         effect_start <= start_nxt;
         if (start_nxt) effect_id <= cur.effect_value;
         busy <= (state_nxt != SSR_IDLE);
         active_slot <= slot_nxt;
         repeat_index <= pass_nxt;
      end
   end

   // ----------------------------------------
   // wait timer
   // ----------------------------------------
   ssr_delay_timer #(
      .UNIT_CYCLES(UNIT_CYCLES)
   ) u_timer (
      .clock(clock),
      .resetn(resetn),
      .start(timer_start),
      .units(cur.effect_value),
      .done(timer_done)
   );
endmodule
`default_nettype wire

/* File: test/ssr_repeat_monitor.sv */
// checker on the slot repeat block ports
// assumes one clock and a synchronous active-low reset
`timescale 1ns/1ps
`default_nettype none
module ssr_repeat_monitor
   import ssr_pkg::*;
#(
   parameter int SLOTS = 8,
   parameter int UNIT_CYCLES = 4
) (
   input wire logic clock,
   input wire logic resetn,
   input wire ssr_req_t reg_req,
   input wire logic [7:0] reg_rdata,
   input wire logic reg_hit,
   input wire ssr_entry_t [SLOTS-1:0] slot_entries,
   input wire logic go,
   input wire logic effect_start,
   input wire logic [6:0] effect_id,
   input wire logic effect_done,
   input wire logic busy,
   input wire logic [2:0] active_slot,
   input wire logic [1:0] repeat_index
);
   // shadow of both registers; a write in mid-run would upset the limit checks
   logic [15:0] shadow_r;
   wire logic [1:0] field = shadow_r[active_slot*2 +: 2];
   wire logic first_fx = slot_entries[0] != 8'h00 && !slot_entries[0].delay_flag;
   always_ff @(posedge clock) begin
      if (!resetn) begin
         shadow_r <= 16'h0000;
      end else if (reg_req.wr && reg_req.addr == 8'h17) begin
         shadow_r[7:0] <= reg_req.wdata;
      end else if (reg_req.wr && reg_req.addr == 8'h18) begin
         shadow_r[15:8] <= reg_req.wdata;
      end
   end
   default clocking cb @(posedge clock); endclocking
   default disable iff (!resetn);
   sequence s_launch;
      go && !busy && first_fx ##1 busy;
   endsequence
   sequence s_wr_rd;
      reg_req.wr && reg_req.addr == 8'h18 ##1 reg_req.rd && reg_req.addr == 8'h18;
   endsequence
   AST_RST_QUIET: assert property (disable iff (1'b0) !resetn |=> !busy && !effect_start)
      else $error("outputs active after reset");
   AST_LAUNCH: assert property (s_launch |=> effect_start && effect_id == slot_entries[0])
      else $error("first effect not launched");
   AST_READBACK: assert property (s_wr_rd |=> reg_hit && reg_rdata == $past(reg_req.wdata, 2))
      else $error("register readback wrong");
   AST_REP_LIMIT: assert property (busy |-> repeat_index <= field)
      else $error("repeat index past its field");
   AST_ADVANCE: assert property (busy && $past(busy) && active_slot != $past(active_slot) |->
      active_slot == $past(active_slot) + 3'h1 && $past(repeat_index) == $past(field))
      else $error("slot left early or out of order");
   AST_WAIT_QUIET: assert property (effect_start |-> !slot_entries[active_slot].delay_flag)
      else $error("effect launched for a wait entry");
   AST_FX_ID: assert property (effect_start |-> effect_id == slot_entries[active_slot])
      else $error("effect id not the slot value");
   AST_STOP: assert property (busy && slot_entries[active_slot] == 8'h00 |-> ##[1:3] !busy)
      else $error("no stop at end marker");
endmodule
bind ssr_sequencer_repeat ssr_repeat_monitor #(.SLOTS(SLOTS), .UNIT_CYCLES(UNIT_CYCLES)) u_mon (
   .clock, .resetn, .reg_req, .reg_rdata, .reg_hit, .slot_entries, .go,
   .effect_start, .effect_id, .effect_done, .busy, .active_slot, .repeat_index
);
`default_nettype wire

/* File: test/ssr_engine_model.sv */
// waveform engine stand-in: one effect_done per effect_start
// assumes effect_start is a one-cycle pulse
`timescale 1ns/1ps
`default_nettype none
module ssr_engine_model (
   input wire logic clock,
   input wire logic resetn,
   input wire logic effect_start,
   output logic effect_done
);
   logic [3:0] cnt_r;
   logic slow_r;
   // latency alternates quick and slow so both answer paths are seen
   always_ff @(posedge clock) begin
      if (!resetn) begin
         cnt_r <= 4'h0;
         slow_r <= 1'b0;
      end else if (effect_start) begin
         cnt_r <= slow_r ? 4'h9 : 4'h1;
         slow_r <= !slow_r;
      end else if (cnt_r != 4'h0) begin
         cnt_r <= cnt_r - 4'h1;
      end
   end
   assign effect_done = cnt_r == 4'h1;
endmodule
`default_nettype wire

/* File: test/ssr_sequencer_repeat_tb.sv */
// self-checking bench for the slot repeat block
// assumes the engine model on the far side; timer unit shortened to 4 cycles
`timescale 1ns/1ps
`default_nettype none
module ssr_sequencer_repeat_tb
   import ssr_pkg::*;
;
   logic clock = 1'b0;
   logic resetn = 1'b0;
   logic go = 1'b0;
   ssr_req_t reg_req = '0;
   ssr_entry_t [7:0] slot_entries = '0;
   logic effect_start, effect_done, busy, reg_hit;
   logic [7:0] reg_rdata;
   logic [6:0] effect_id, last_id;
   logic [2:0] active_slot;
   logic [1:0] repeat_index;
   int n_mismatch = 0;
   int checked = 0;
   int n_fx = 0;
   // rows: address, write data, expected readback (0x19 is unmapped)
   logic [23:0] rows [4] = '{24'h17e4e4, 24'h181b1b, 24'h19ff00, 24'h173939};
   always #20 clock = !clock;
   ssr_sequencer_repeat #(.SLOTS(8), .UNIT_CYCLES(4)) dut (
      .clock, .resetn, .reg_req, .reg_rdata, .reg_hit, .slot_entries, .go,
      .effect_start, .effect_id, .effect_done, .busy, .active_slot, .repeat_index
   );
   ssr_engine_model u_eng (.clock, .resetn, .effect_start, .effect_done);
   // count launches at the falling edge, where the pulse has settled
   always @(negedge clock) begin
      if (effect_start === 1'b1) begin
         n_fx++;
         last_id = effect_id;
      end
   end
   task automatic summarize();
      $display("mismatches %0d, comparisons %0d", n_mismatch, checked);
      if (n_mismatch == 0 && checked > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
      @(negedge clock);
      reg_req = '{wr: w, rd: !w, addr: a, wdata: d};
      @(negedge clock);
      reg_req = '0;
   endtask
   // go pulse, a second go while busy, then wait for the end under a bound
   task automatic run(input int exp_fx, input logic [6:0] exp_last);
      int i;
      @(negedge clock);
      go = 1'b1;
      n_fx = 0;
      @(negedge clock);
      go = 1'b0;
      for (i = 0; i < 3000 && (busy === 1'b1 || i < 2); i++) begin
         @(negedge clock);
         go = (i == 5);
      end
      if (i >= 3000) begin
         n_mismatch++;
         summarize();
      end
      chk(8'(n_fx), 8'(exp_fx));
      chk({1'b0, last_id}, {1'b0, exp_last});
   endtask
   initial begin
      int k;
      repeat (2) @(negedge clock);
      resetn = 1'b1;
      for (k = 0; k < 2; k++) begin
         acc(1'b0, 8'h17 + 8'(k), 8'h00);
         chk(reg_rdata, 8'h00);
      end
      for (k = 0; k < 4; k++) begin
         acc(1'b1, rows[k][23:16], rows[k][15:8]);
         acc(1'b0, rows[k][23:16], 8'h00);
         chk(reg_rdata, rows[k][7:0]);
         chk({7'h00, reg_hit}, {7'h00, rows[k][23:16] != 8'h19});
      end
      // effect twice, wait of 2 units three times, effect four times, end marker
      slot_entries[0] = 8'h05;
      slot_entries[1] = 8'h82;
      slot_entries[2] = 8'h07;
      run(6, 7'h07);
      // all eight slots used, slot eight four times: stop after the eighth
      acc(1'b1, 8'h17, 8'h00);
      acc(1'b1, 8'h18, 8'hc0);
      for (k = 0; k < 8; k++) slot_entries[k] = 8'(k + 1);
      run(11, 7'h08);
      // reset in mid-run clears the sequence and the registers
      @(negedge clock);
      go = 1'b1;
      @(negedge clock);
      go = 1'b0;
      repeat (3) @(negedge clock);
      resetn = 1'b0;
      repeat (2) @(negedge clock);
      resetn = 1'b1;
      chk({7'h00, busy}, 8'h00);
      acc(1'b0, 8'h18, 8'h00);
      chk(reg_rdata, 8'h00);
      summarize();
   end
endmodule
`default_nettype wire
